/* File: pkg/can_fault_pkg.sv */
// Register map, field positions, limits and state codes of the CAN fault-confinement block.
package can_fault_pkg;

    // ==========================================================================
    // Register map (byte addresses, one 32-bit word each)
    // ==========================================================================
    localparam int          ADDR_W          = 8;
    localparam logic [7:0]  OFF_STATUS      = 8'h00;
    localparam logic [7:0]  OFF_COUNTERS    = 8'h04;
    localparam logic [7:0]  OFF_MASTER_CTRL = 8'h08;
    localparam logic [7:0]  OFF_IRQ_STATUS  = 8'h0C;
    localparam logic [7:0]  OFF_IRQ_MASK    = 8'h10;

    // ==========================================================================
    // Field positions
    // ==========================================================================
    localparam int STUFF_BIT   = 20;
    localparam int NOACK_BIT   = 19;
    localparam int BUS_OFF_BIT = 18;
    localparam int PASSIVE_BIT = 17;
    localparam int WARN_BIT    = 16;
    localparam int CCR_BIT     = 0;
    localparam int ABO_BIT     = 7;
    localparam int TEC_LSB     = 0;
    localparam int REC_LSB     = 16;

    // Interrupt status and mask layout.
    localparam int IRQ_W          = 6;
    localparam int IRQ_STUFF      = 0;
    localparam int IRQ_NOACK      = 1;
    localparam int IRQ_BUS_OFF    = 2;
    localparam int IRQ_PASSIVE    = 3;
    localparam int IRQ_WARN       = 4;
    localparam int IRQ_BUS_ON     = 5;

    // ==========================================================================
    // Counter widths, limits and reset values
    // ==========================================================================
    localparam int          CNT_W           = 9;
    localparam int          REC_W           = 8;
    localparam logic [8:0]  BUS_OFF_LIMIT   = 9'h100;
    localparam logic [8:0]  PASSIVE_LIMIT   = 9'h080;
    localparam logic [8:0]  WARN_LIMIT      = 9'h060;
    localparam logic [8:0]  REC_CEILING     = 9'h0FF;
    localparam logic [8:0]  CNT_RESET       = 9'h000;
    localparam logic [31:0] WORD_RESET      = 32'h0000_0000;
    localparam logic [5:0]  IRQ_RESET       = 6'h00;

    // Bus-off recovery: 128 runs of 11 received bits.
    localparam int RECOVERY_RUNS     = 128;
    localparam int RECOVERY_RUN_BITS = 11;
    localparam int RECOVERY_BITS     = RECOVERY_RUNS * RECOVERY_RUN_BITS;

    // ==========================================================================
    // Fault-confinement states
    // ==========================================================================
    typedef enum logic [2:0] {
        ST_ACTIVE  = 3'b001,
        ST_PASSIVE = 3'b010,
        ST_BUS_OFF = 3'b100
    } fault_state_t;

endpackage : can_fault_pkg

/* File: logic/bus_off_recovery.sv */
// Counter of received bits that releases the bus-off state automatically.
`timescale 1ns/1ps
module bus_off_recovery #(
    parameter int RUN_BITS = 1408
) (
    input  wire logic ref_clk_i,
    input  wire logic rst_i,
    input  wire logic run_i,
    input  wire logic bit_i,
    output logic      done_o
);

    localparam int          CW      = $clog2(RUN_BITS + 1);
    localparam logic [CW-1:0] LAST  = CW'(RUN_BITS - 1);

    logic [CW-1:0] count_r;
    logic [CW-1:0] count_nxt;
    logic          done_r;
    logic          done_nxt;

    // ==========================================================================
    // Bit counting
    // ==========================================================================
    // The count restarts whenever recovery is not armed, so a fresh bus-off
    // always waits the full number of bits.
    always_comb begin
        count_nxt = count_r;
        done_nxt  = 1'b0;
        if (!run_i) begin
            count_nxt = '0;
        end else if (bit_i) begin
            if (count_r == LAST) begin
                count_nxt = '0;
                done_nxt  = 1'b1;
            end else begin
                count_nxt = count_r + CW'(1);
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            count_r <= '0;
            done_r  <= 1'b0;
        end else begin
            count_r <= count_nxt;
            done_r  <= done_nxt;
        end
    end

    assign done_o = done_r;

endmodule : bus_off_recovery

/* File: logic/can_fault_confine.sv */
// Error flags and fault-confinement states of a CAN controller, with an Avalon-MM register slave.
//
// The Avalon-MM interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module can_fault_confine
    import can_fault_pkg::*;
#(
    parameter int RECOVERY_LEN = RECOVERY_BITS
) (
    input  wire logic              ref_clk_i,
    input  wire logic              rst_i,
    input  wire logic [ADDR_W-1:0] avs_address_i,
    input  wire logic              avs_read_i,
    input  wire logic              avs_write_i,
    input  wire logic [31:0]       avs_writedata_i,
    input  wire logic [3:0]        avs_byteenable_i,
    output logic      [31:0]       avs_readdata_o,
    output logic                   avs_waitrequest_o,
    input  wire logic              stuff_error_i,
    input  wire logic              ack_error_i,
    input  wire logic              tec_inc_i,
    input  wire logic [3:0]        tec_inc_amt_i,
    input  wire logic              tec_dec_i,
    input  wire logic              rec_inc_i,
    input  wire logic [3:0]        rec_inc_amt_i,
    input  wire logic              rec_dec_i,
    input  wire logic              rx_bit_i,
    output logic                   bus_off_o,
    output logic                   error_passive_o,
    output logic                   warning_o,
    output logic                   irq_o
);

    // ==========================================================================
    // Helpers
    // ==========================================================================
    function automatic logic hits(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] off);
        hits = (addr == off);
    endfunction : hits

    // Saturating counter step shared by both error counters.
    function automatic logic [CNT_W-1:0] step_count(input logic [CNT_W-1:0] cnt, input logic inc,
                                                    input logic [3:0] amt, input logic dec,
                                                    input logic [CNT_W-1:0] ceiling);
        logic [CNT_W:0] sum;
        sum = {1'b0, cnt};
        if (inc) begin
            sum = sum + {6'h00, amt};
        end
        if (dec && (sum != '0)) begin
            sum = sum - 10'h001;
        end
        if (sum > {1'b0, ceiling}) begin
            sum = {1'b0, ceiling};
        end
        step_count = sum[CNT_W-1:0];
    endfunction : step_count

    // ==========================================================================
    // Declarations
    // ==========================================================================
    logic             wait_r;
    logic             wait_nxt;
    logic [31:0]      rdata_r;
    logic [31:0]      rdata_nxt;
    logic             ack;
    logic             wr;
    logic             rd;
    logic [31:0]      wmask;
    logic [31:0]      wbits;
    fault_state_t     state_r;
    fault_state_t     state_nxt;
    logic [CNT_W-1:0] tec_r;
    logic [CNT_W-1:0] tec_nxt;
    logic [REC_W-1:0] rec_r;
    logic [REC_W-1:0] rec_nxt;
    logic [CNT_W-1:0] rec_step;
    logic             ccr_r;
    logic             ccr_nxt;
    logic             abo_r;
    logic             abo_nxt;
    logic             ccr_release;
    logic             recovery_done;
    logic             stuff_r;
    logic             stuff_nxt;
    logic             noack_r;
    logic             noack_nxt;
    logic             bus_off_r;
    logic             passive_r;
    logic             warn_r;
    logic             warn_nxt;
    logic [IRQ_W-1:0] irq_status_r;
    logic [IRQ_W-1:0] irq_status_nxt;
    logic [IRQ_W-1:0] irq_mask_r;
    logic [IRQ_W-1:0] irq_mask_nxt;
    logic [IRQ_W-1:0] events;
    logic             irq_r;
    logic             irq_nxt;

    // ==========================================================================
    // Avalon-MM slave
    // ==========================================================================
    // Every access waits exactly one cycle; all effects happen on the edge that
    // drops waitrequest, so write data and read data line up with that edge.
    assign ack   = (avs_read_i || avs_write_i) && wait_r;
    assign wr    = ack && avs_write_i;
    assign rd    = ack && avs_read_i;
    assign wmask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                    {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
    assign wbits = avs_writedata_i & wmask;

    always_comb begin
        wait_nxt  = wait_r ? !ack : 1'b1;
        rdata_nxt = rdata_r;
        if (rd) begin
            rdata_nxt = WORD_RESET;
            if (hits(avs_address_i, OFF_STATUS)) begin
                rdata_nxt[STUFF_BIT]   = stuff_r;
                rdata_nxt[NOACK_BIT]   = noack_r;
                rdata_nxt[BUS_OFF_BIT] = bus_off_r;
                rdata_nxt[PASSIVE_BIT] = passive_r;
                rdata_nxt[WARN_BIT]    = warn_r;
            end else if (hits(avs_address_i, OFF_COUNTERS)) begin
                rdata_nxt[TEC_LSB +: CNT_W] = tec_r;
                rdata_nxt[REC_LSB +: REC_W] = rec_r;
            end else if (hits(avs_address_i, OFF_MASTER_CTRL)) begin
                rdata_nxt[CCR_BIT] = ccr_r;
                rdata_nxt[ABO_BIT] = abo_r;
            end else if (hits(avs_address_i, OFF_IRQ_STATUS)) begin
                rdata_nxt[IRQ_W-1:0] = irq_status_r;
            end else if (hits(avs_address_i, OFF_IRQ_MASK)) begin
                rdata_nxt[IRQ_W-1:0] = irq_mask_r;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            wait_r  <= 1'b1;
            rdata_r <= WORD_RESET;
        end else begin
            wait_r  <= wait_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign avs_waitrequest_o = wait_r;
    assign avs_readdata_o    = rdata_r;

    // ==========================================================================
    // Fault-confinement state and error counters
    // ==========================================================================
    assign ccr_release = wr && hits(avs_address_i, OFF_MASTER_CTRL) && avs_byteenable_i[0]
                         && !avs_writedata_i[CCR_BIT] && ccr_r;
    assign rec_step    = step_count({1'b0, rec_r}, rec_inc_i, rec_inc_amt_i, rec_dec_i, REC_CEILING);

    always_comb begin
        state_nxt = state_r;
        tec_nxt   = tec_r;
        rec_nxt   = rec_r;
        case (state_r)
            ST_ACTIVE, ST_PASSIVE: begin
                tec_nxt = step_count(tec_r, tec_inc_i, tec_inc_amt_i, tec_dec_i, BUS_OFF_LIMIT);
                rec_nxt = rec_step[REC_W-1:0];
                if (tec_nxt >= BUS_OFF_LIMIT) begin
                    state_nxt = ST_BUS_OFF;
                end else if (tec_nxt >= PASSIVE_LIMIT) begin
                    state_nxt = ST_PASSIVE;
                end else begin
                    state_nxt = ST_ACTIVE;
                end
            end
            ST_BUS_OFF: begin
                // Counter inputs are ignored here: the node takes no part in traffic.
                if (ccr_release || recovery_done) begin
                    state_nxt = ST_ACTIVE;
                    tec_nxt   = CNT_RESET;
                    rec_nxt   = REC_W'(CNT_RESET);
                end
            end
            default: begin
                state_nxt = ST_ACTIVE;
                tec_nxt   = CNT_RESET;
                rec_nxt   = REC_W'(CNT_RESET);
            end
        endcase
    end

    // Entering bus-off without auto-bus-on raises the request bit, so software
    // has something to clear when it decides the node may rejoin the bus.
    always_comb begin
        ccr_nxt = ccr_r;
        abo_nxt = abo_r;
        if (wr && hits(avs_address_i, OFF_MASTER_CTRL) && avs_byteenable_i[0]) begin
            ccr_nxt = avs_writedata_i[CCR_BIT];
            abo_nxt = avs_writedata_i[ABO_BIT];
        end
        if ((state_nxt == ST_BUS_OFF) && (state_r != ST_BUS_OFF) && !abo_nxt) begin
            ccr_nxt = 1'b1;
        end
    end

    bus_off_recovery #(
        .RUN_BITS (RECOVERY_LEN)
    ) u_recovery (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .run_i     ((state_r == ST_BUS_OFF) && abo_r),
        .bit_i     (rx_bit_i),
        .done_o    (recovery_done)
    );

    // ==========================================================================
    // Error flags
    // ==========================================================================
    // Write one clears a sticky flag; an event in the same cycle wins.
    always_comb begin
        stuff_nxt = stuff_r;
        noack_nxt = noack_r;
        if (wr && hits(avs_address_i, OFF_STATUS)) begin
            stuff_nxt = stuff_r & !wbits[STUFF_BIT];
            noack_nxt = noack_r & !wbits[NOACK_BIT];
        end
        stuff_nxt = stuff_nxt | stuff_error_i;
        noack_nxt = noack_nxt | ack_error_i;
        warn_nxt  = (tec_nxt >= WARN_LIMIT) || ({1'b0, rec_nxt} >= WARN_LIMIT);
    end

    // ==========================================================================
    // Interrupts
    // ==========================================================================
    always_comb begin
        events                 = '0;
        events[IRQ_STUFF]      = stuff_error_i;
        events[IRQ_NOACK]      = ack_error_i;
        events[IRQ_BUS_OFF]    = (state_nxt == ST_BUS_OFF) && (state_r != ST_BUS_OFF);
        events[IRQ_PASSIVE]    = (state_nxt == ST_PASSIVE) && (state_r != ST_PASSIVE);
        events[IRQ_WARN]       = warn_nxt && !warn_r;
        events[IRQ_BUS_ON]     = (state_r == ST_BUS_OFF) && (state_nxt != ST_BUS_OFF);
        irq_mask_nxt           = irq_mask_r;
        irq_status_nxt         = irq_status_r;
        if (wr && hits(avs_address_i, OFF_IRQ_MASK)) begin
            irq_mask_nxt = (irq_mask_r & ~wmask[IRQ_W-1:0]) | wbits[IRQ_W-1:0];
        end
        // Only the bits that the read returns are cleared, so nothing is lost.
        if (rd && hits(avs_address_i, OFF_IRQ_STATUS)) begin
            irq_status_nxt = '0;
        end
        irq_status_nxt = irq_status_nxt | events;
        irq_nxt        = |(irq_status_nxt & irq_mask_nxt);
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state_r      <= ST_ACTIVE;
            tec_r        <= CNT_RESET;
            rec_r        <= REC_W'(CNT_RESET);
            ccr_r        <= 1'b0;
            abo_r        <= 1'b0;
            stuff_r      <= 1'b0;
            noack_r      <= 1'b0;
            bus_off_r    <= 1'b0;
            passive_r    <= 1'b0;
            warn_r       <= 1'b0;
            irq_status_r <= IRQ_RESET;
            irq_mask_r   <= IRQ_RESET;
            irq_r        <= 1'b0;
        end else begin
            state_r      <= state_nxt;
            tec_r        <= tec_nxt;
            rec_r        <= rec_nxt;
            ccr_r        <= ccr_nxt;
            abo_r        <= abo_nxt;
            stuff_r      <= stuff_nxt;
            noack_r      <= noack_nxt;
            bus_off_r    <= (state_nxt == ST_BUS_OFF);
            passive_r    <= (state_nxt == ST_PASSIVE);
            warn_r       <= warn_nxt;
            irq_status_r <= irq_status_nxt;
            irq_mask_r   <= irq_mask_nxt;
            irq_r        <= irq_nxt;
        end
    end

    assign bus_off_o       = bus_off_r;
    assign error_passive_o = passive_r;
    assign warning_o       = warn_r;
    assign irq_o           = irq_r;

    // ==========================================================================
    // Assertions
    // ==========================================================================
    default clocking cb_chk @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    property p_stuff_set;
        stuff_error_i |=> stuff_r;
    endproperty
    a_stuff_set: assert property (p_stuff_set) else $error("stuff flag not set");
    property p_noack_set;
        ack_error_i |=> noack_r ##1 (noack_r || $past(wr));
    endproperty
    a_noack_set: assert property (p_noack_set) else $error("no-ack flag not set");
    property p_noack_cause;
        $rose(noack_r) |-> $past(ack_error_i);
    endproperty
    a_noack_cause: assert property (p_noack_cause) else $error("no-ack flag without cause");
    property p_bus_off_limit;
        (tec_r == BUS_OFF_LIMIT) |-> (bus_off_o && (state_r == ST_BUS_OFF));
    endproperty
    a_bus_off_limit: assert property (p_bus_off_limit) else $error("bus-off not entered at limit");
    property p_bus_off_frozen;
        (bus_off_o && (state_nxt == ST_BUS_OFF)) |=> (bus_off_o && $stable(rec_r) && $stable(tec_r));
    endproperty
    a_bus_off_frozen: assert property (p_bus_off_frozen) else $error("counters moved in bus-off");
    property p_ccr_exit;
        (bus_off_o && ccr_release) |=> (!bus_off_o && !ccr_r);
    endproperty
    a_ccr_exit: assert property (p_ccr_exit) else $error("request clear did not end bus-off");
    property p_auto_exit;
        (bus_off_o && abo_r && recovery_done) |=> (state_r == ST_ACTIVE);
    endproperty
    a_auto_exit: assert property (p_auto_exit) else $error("auto recovery did not end bus-off");
    property p_exit_clears;
        $fell(bus_off_o) |-> ((tec_r == CNT_RESET) && (rec_r == REC_W'(CNT_RESET)));
    endproperty
    a_exit_clears: assert property (p_exit_clears) else $error("counters not cleared on exit");
    property p_passive;
        ((tec_r >= PASSIVE_LIMIT) && (tec_r < BUS_OFF_LIMIT)) |-> error_passive_o;
    endproperty
    a_passive: assert property (p_passive) else $error("passive flag missing");
    property p_active;
        (!error_passive_o && !bus_off_o) |-> ((state_r == ST_ACTIVE) && (tec_r < PASSIVE_LIMIT));
    endproperty
    a_active: assert property (p_active) else $error("not error-active");
    property p_warn_set;
        ((tec_r >= WARN_LIMIT) || ({1'b0, rec_r} >= WARN_LIMIT)) |-> warning_o;
    endproperty
    a_warn_set: assert property (p_warn_set) else $error("warning flag missing");
    property p_warn_clear;
        !warning_o |-> ((tec_r < WARN_LIMIT) && ({1'b0, rec_r} < WARN_LIMIT));
    endproperty
    a_warn_clear: assert property (p_warn_clear) else $error("warning clear above level");
    property p_reserved_zero;
        (rd && hits(avs_address_i, OFF_STATUS)) |=> (avs_readdata_o[15:6] == 10'h000) && !avs_waitrequest_o;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved status bits not zero");

    c_bus_off:  cover property ($rose(bus_off_o));
    c_auto_on:  cover property (recovery_done ##1 !bus_off_o);
    c_passive:  cover property ($rose(error_passive_o));
    c_irq:      cover property ($rose(irq_o));

endmodule : can_fault_confine

/* File: tb/can_node_model.sv */
// Behavioural model of the far CAN nodes, which raise the error events the block confines.
`timescale 1ns/1ps
module can_node_model (
    input  wire logic ref_clk_i,
    output logic       stuff_o,
    output logic       ack_o,
    output logic       tec_inc_o,
    output logic       rec_inc_o,
    output logic [3:0] amt_o,
    output logic       rx_bit_o
);
    initial {stuff_o, ack_o, tec_inc_o, rec_inc_o, amt_o, rx_bit_o} = '0;
    task pulse(input bit ack);
        @(posedge ref_clk_i);
        if (ack) ack_o <= 1'h1;
        else stuff_o <= 1'h1;
        @(posedge ref_clk_i);
        {stuff_o, ack_o} <= 2'h0;
    endtask : pulse
    // Errors arrive in steps of at most 15, the most one increment pulse can carry.
    task add(input bit rx, input int total);
        while (total > 0) begin
            @(posedge ref_clk_i);
            amt_o <= (total > 15) ? 4'hF : total[3:0];
            tec_inc_o <= !rx;
            rec_inc_o <= rx;
            total -= 15;
        end
        @(posedge ref_clk_i);
        {tec_inc_o, rec_inc_o} <= 2'h0;
    endtask : add
    task rx_bits(input int n);
        repeat (n) begin
            @(posedge ref_clk_i);
            rx_bit_o <= 1'h1;
            @(posedge ref_clk_i);
            rx_bit_o <= 1'h0;
        end
    endtask : rx_bits
endmodule : can_node_model

/* File: tb/testbench.sv */
// Self-checking testbench of the CAN fault-confinement block.
`timescale 1ns/1ps
module testbench;
    import can_fault_pkg::*;
    logic        ref_clk_i, rst_i, avs_read_i, avs_write_i, stuff, ack, tinc, rinc, rxb, dec;
    logic [7:0]  avs_address_i;
    logic [31:0] avs_writedata_i, avs_readdata_o;
    logic [3:0]  amt, be;
    logic        avs_waitrequest_o, bus_off_o, error_passive_o, warning_o, irq_o;
    int          errors, n_compared;
    // The recovery run is shortened to 4 bits so auto bus-on finishes in under a dozen cycles.
    can_fault_confine #(.RECOVERY_LEN(4)) dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(be), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .stuff_error_i(stuff), .ack_error_i(ack),
        .tec_inc_i(tinc), .tec_inc_amt_i(amt), .tec_dec_i(dec), .rec_inc_i(rinc), .rec_inc_amt_i(amt),
        .rec_dec_i(dec), .rx_bit_i(rxb), .bus_off_o(bus_off_o), .error_passive_o(error_passive_o),
        .warning_o(warning_o), .irq_o(irq_o));
    can_node_model node (.ref_clk_i(ref_clk_i), .stuff_o(stuff), .ack_o(ack), .tec_inc_o(tinc),
        .rec_inc_o(rinc), .amt_o(amt), .rx_bit_o(rxb));
    // ==========================================================================
    // Shared tasks
    // ==========================================================================
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge ref_clk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_read_i <= !wr;
        avs_write_i <= wr;
        do @(posedge ref_clk_i); while (avs_waitrequest_o !== 1'h0);
        q = avs_readdata_o;
        avs_read_i <= 1'h0;
        avs_write_i <= 1'h0;
    endtask : bus
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'h0, a, 32'h0000_0000, q);
        chk(q, exp);
    endtask : rd_chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'h1, a, d, q);
    endtask : wr
    task give_verdict;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict
    // ==========================================================================
    // Scenarios
    // ==========================================================================
    task t_reset;
        rd_chk(OFF_STATUS, 32'h0000_0000);
        wr(OFF_STATUS, 32'hFFFF_FFFF);
        rd_chk(OFF_STATUS, 32'h0000_0000);
        rd_chk(8'h20, 32'h0000_0000);
    endtask : t_reset
    task t_flags;
        wr(OFF_IRQ_MASK, 32'h0000_0002);
        node.pulse(0);
        @(negedge ref_clk_i);
        chk(irq_o, 1'h0);
        rd_chk(OFF_STATUS, 32'h0010_0000);
        node.pulse(1);
        @(negedge ref_clk_i);
        chk(irq_o, 1'h1);
        rd_chk(OFF_STATUS, 32'h0018_0000);
        rd_chk(OFF_IRQ_STATUS, 32'h0000_0003);
        @(negedge ref_clk_i);
        chk(irq_o, 1'h0);
        wr(OFF_STATUS, 32'h0018_0000);
        rd_chk(OFF_STATUS, 32'h0000_0000);
    endtask : t_flags
    task t_bus_off;
        node.add(0, 96);
        rd_chk(OFF_STATUS, 32'h0001_0000);
        rd_chk(OFF_COUNTERS, 32'h0000_0060);
        node.add(0, 32);
        rd_chk(OFF_STATUS, 32'h0003_0000);
        node.add(0, 128);
        rd_chk(OFF_STATUS, 32'h0005_0000);
        chk({bus_off_o, error_passive_o}, 2'h2);
        node.add(1, 10);
        rd_chk(OFF_COUNTERS, 32'h0000_0100);
        rd_chk(OFF_IRQ_STATUS, 32'h0000_001C);
        be <= 4'hE;
        wr(OFF_MASTER_CTRL, 32'h0000_0000);
        be <= 4'hF;
        chk(bus_off_o, 1'h1);
        wr(OFF_MASTER_CTRL, 32'h0000_0000);
        rd_chk(OFF_STATUS, 32'h0000_0000);
        rd_chk(OFF_COUNTERS, 32'h0000_0000);
    endtask : t_bus_off
    task t_auto;
        node.add(1, 96);
        rd_chk(OFF_COUNTERS, 32'h0060_0000);
        chk(warning_o, 1'h1);
        @(posedge ref_clk_i);
        dec <= 1'h1;
        @(posedge ref_clk_i);
        dec <= 1'h0;
        @(negedge ref_clk_i);
        chk(warning_o, 1'h0);
        rd_chk(OFF_COUNTERS, 32'h005F_0000);
        wr(OFF_MASTER_CTRL, 32'h0000_0080);
        node.add(0, 256);
        @(negedge ref_clk_i);
        chk(bus_off_o, 1'h1);
        node.rx_bits(4);
        repeat (3) @(negedge ref_clk_i);
        chk(bus_off_o, 1'h0);
        rd_chk(OFF_COUNTERS, 32'h0000_0000);
    endtask : t_auto
    initial begin
        ref_clk_i = 1'h0;
        forever #50 ref_clk_i = ~ref_clk_i;
    end
    initial begin
        {rst_i, dec, avs_read_i, avs_write_i, avs_address_i, avs_writedata_i} = '0;
        be = 4'hF;
        rst_i = 1'h1;
        repeat (20) @(posedge ref_clk_i);
        rst_i <= 1'h0;
        t_reset;
        t_flags;
        t_bus_off;
        t_auto;
        give_verdict;
    end
    initial begin
        #400_000;
        errors++;
        $display("[ERR] %0t run did not finish", $time);
        give_verdict;
    end
endmodule : testbench
